// ### src/led_pwm_pkg.sv
// constants, register map and types of the sixteen channel led pwm frame controller
package led_pwm_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_CONFIG    = 8'h00;
	localparam logic [7:0] ADDR_LEDCTL_HI = 8'h01;
	localparam logic [7:0] ADDR_LEDCTL_LO = 8'h02;
	localparam logic [7:0] ADDR_EFFECT    = 8'h03;
	localparam logic [7:0] ADDR_FUNC      = 8'h04;
	localparam logic [7:0] ADDR_DIR       = 8'h05;
	localparam logic [7:0] ADDR_LEVEL     = 8'h06;
	localparam logic [7:0] ADDR_IRQEN     = 8'h07;
	localparam logic [7:0] ADDR_STATE     = 8'h08;
	localparam logic [7:0] ADDR_SRATE     = 8'h09;
	localparam logic [7:0] ADDR_DUTY_LO   = 8'h10;
	localparam logic [7:0] ADDR_DUTY_HI   = 8'h1f;
	localparam logic [7:0] ADDR_FRAME_LO  = 8'h20;
	localparam logic [7:0] ADDR_FRAME_HI  = 8'haf;
	localparam logic [7:0] ADDR_COMMIT    = 8'hb0;
	localparam logic [7:0] ADDR_DELAY     = 8'hb6;
	localparam logic [7:0] ADDR_START     = 8'hb7;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CONFIG = 8'h80;
	localparam logic [7:0] RST_LEDCTL = 8'hff;
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_LEVEL  = 8'hff;
	// ==========================================================
	// sizes and field positions
	localparam int NUM_CH     = 16;
	localparam int NUM_GPIO   = 8;
	localparam int NUM_FRAMES = 8;
	localparam int MEM_BYTES  = 144;
	localparam logic [7:0] FRAME_BYTES    = 8'h12;
	localparam logic [7:0] FRAME_ON_HI    = 8'h00;
	localparam logic [7:0] FRAME_ON_LO    = 8'h01;
	localparam logic [7:0] FRAME_DUTY_OFS = 8'h02;
	localparam int MODE_MSB = 6;
	localparam int MODE_LSB = 5;
	localparam int AUDIO_MOD_BIT = 4;
	localparam int ISEL_MSB      = 6;
	localparam int ISEL_LSB      = 4;
	localparam int AGC_EN_BIT    = 3;
	localparam int GAIN_CODE_MSB = 2;
	localparam int GAIN_CODE_LSB = 0;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 5;
	localparam logic [4:0] GAIN_STEP_DB = 5'h03;
	// ==========================================================
	// timing
	localparam int CLK_HZ          = 10_000_000;
	localparam int FRAME_BASE_MS   = 32;
	localparam int SAMPLE_BASE_HZ  = 15_625;
	localparam int FRAME_BASE_DFLT = CLK_HZ / 1000 * FRAME_BASE_MS;
	localparam int SAMPLE_UNIT     = CLK_HZ / SAMPLE_BASE_HZ;
	// ==========================================================
	// operating modes
	typedef enum logic [1:0] {MODE_PWM, MODE_AUTO, MODE_AUDIO, MODE_RSVD} op_mode_e;
	typedef logic [7:0] duty_t;
endpackage

// ### src/pwm_bank_if.sv
// signals between the register side and the channel pwm bank
`timescale 1ns/100ps
`default_nettype none
interface pwm_bank_if;
	import led_pwm_pkg::*;
	duty_t       duty [NUM_CH];
	logic [15:0] chan_on;
	logic [15:0] pwm;
	modport ctrl (output duty, output chan_on, input pwm);
	modport bank (input duty, input chan_on, output pwm);
endinterface
`default_nettype wire

// ### src/pwm_channel_bank.sv
// sixteen channel 256 step pwm generator
`timescale 1ns/100ps
`default_nettype none
module pwm_channel_bank
	import led_pwm_pkg::*;
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// channel settings and outputs
	pwm_bank_if.bank   bus
);
	logic [7:0]  step_q;
	logic [15:0] pwm_q;

	assign bus.pwm = pwm_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_q <= RST_ZERO;
		end else begin
			step_q <= step_q + 8'h01;
		end
	end

	// high for duty of the 256 steps, so the mean is full scale times duty over 256
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				pwm_q[c] <= 1'b0;
			end else begin
				pwm_q[c] <= bus.chan_on[c] && (step_q < bus.duty[c]);
			end
		end
	end
endmodule
`default_nettype wire

// ### src/led_pwm_frame_controller.sv
// register map, frame player, gpio and audio settings of the led controller
`timescale 1ns/100ps
`default_nettype none
module led_pwm_frame_controller
	import led_pwm_pkg::*;
#(
	parameter int unsigned FRAME_BASE_CYCLES = FRAME_BASE_DFLT
) (
	// clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_N,
	// register port
	input  wire logic        I_WR_EN,
	input  wire logic        I_RD_EN,
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	output logic      [7:0]  O_RDATA,
	output logic             O_RDATA_VALID,
	// led channels and settings
	output logic      [15:0] O_CHAN_PWM,
	output logic      [2:0]  O_FULL_SCALE_SEL,
	// gpio on channels 9..16
	input  wire logic [7:0]  I_GPIO_IN,
	output logic      [7:0]  O_GPIO_OUT,
	output logic      [7:0]  O_GPIO_OE_N,
	output logic             O_IRQ_N,
	// audio
	input  wire logic [7:0]  I_AUDIO_LEVEL,
	output logic             O_ADC_SAMPLE,
	output logic      [4:0]  O_AUDIO_GAIN_DB,
	output logic             O_AUDIO_MOD_EN,
	output logic             O_AGC_EN
);
	// ==========================================================
	// state
	logic [7:0]  config_q, ledctl_hi_q, ledctl_lo_q, effect_q;
	logic [7:0]  func_q, dir_q, level_q, irqen_q, srate_q, delay_q, start_q;
	logic [7:0]  state_q, rdata_q;
	logic        rvalid_q, irq_n_q, sample_q;
	duty_t       shadow_q [NUM_CH];
	duty_t       commit_q [NUM_CH];
	duty_t       frm_duty_q [NUM_CH];
	logic [15:0] frm_on_q;
	duty_t       frame_mem [MEM_BYTES];
	logic [2:0]  cur_frame_q;
	logic [1:0]  mode_prev_q;
	logic [31:0] timer_q;
	logic [17:0] srate_cnt_q;
	logic [7:0]  gpio_out_q, gpio_oe_n_q;
	logic [4:0]  gain_q;
	logic [2:0]  isel_q;
	logic        amod_q, agc_en_q;

	pwm_bank_if bank_bus ();

	pwm_channel_bank u_bank (
		.clk   (I_CORE_CLK),
		.rst_n (I_RST_N),
		.bus   (bank_bus)
	);

	// ==========================================================
	// decode
	wire op_mode_e mode     = op_mode_e'(config_q[MODE_MSB:MODE_LSB]);
	wire           entering = (mode_prev_q != config_q[MODE_MSB:MODE_LSB]);
	wire           wr_duty  = I_WR_EN && I_ADDR >= ADDR_DUTY_LO && I_ADDR <= ADDR_DUTY_HI;
	wire           wr_frame = I_WR_EN && I_ADDR >= ADDR_FRAME_LO && I_ADDR <= ADDR_FRAME_HI;
	wire           wr_commit = I_WR_EN && I_ADDR == ADDR_COMMIT;
	wire           rd_state = I_RD_EN && I_ADDR == ADDR_STATE;
	wire [7:0]     frame_idx = I_ADDR - ADDR_FRAME_LO;
	wire [3:0]     duty_ch   = ~I_ADDR[3:0];
	wire [7:0]     gpio_in_pins = func_q & ~dir_q;
	wire [7:0]     chg       = (I_GPIO_IN ^ state_q) & gpio_in_pins & irqen_q;
	wire           chg_any   = |chg;
	wire [31:0]    hold_cycles = 32'(FRAME_BASE_CYCLES) << delay_q[CODE_MSB:CODE_LSB];
	wire [17:0]    sample_period = 18'(srate_q) * 18'(SAMPLE_UNIT);
	wire           srate_on  = (srate_q != RST_ZERO);
	wire           sample_tick = srate_on && (srate_cnt_q == 18'h00000);
	wire           auto_start = (mode == MODE_AUTO) && entering;
	wire           auto_step  = (mode == MODE_AUTO) && !entering && (timer_q == 32'h0);
	wire           audio_pick = (mode == MODE_AUDIO) && sample_tick;
	wire           load_frame = auto_start || auto_step || audio_pick;
	wire [2:0]     next_frame = auto_start ? start_q[CODE_MSB:CODE_LSB] :
	                            auto_step ? cur_frame_q + 3'h1 :
	                            I_AUDIO_LEVEL[CODE_MSB:CODE_LSB];
	wire [7:0]     fbase     = 8'(next_frame) * FRAME_BYTES;
	wire           direct    = (mode == MODE_PWM) || (mode == MODE_RSVD);
	wire [15:0]    on_sel    = direct ? {ledctl_hi_q, ledctl_lo_q} : frm_on_q;

	// gpio channels never get lighting current
	assign bank_bus.chan_on = on_sel & ~{func_q, RST_ZERO};
	for (genvar c = 0; c < NUM_CH; c++) begin : g_sel
		assign bank_bus.duty[c] = direct ? commit_q[c] : frm_duty_q[c];
	end

	// ==========================================================
	// register writes
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			config_q    <= RST_CONFIG;
			ledctl_hi_q <= RST_LEDCTL;
			ledctl_lo_q <= RST_LEDCTL;
			effect_q    <= RST_ZERO;
			func_q      <= RST_ZERO;
			dir_q       <= RST_ZERO;
			level_q     <= RST_LEVEL;
			irqen_q     <= RST_ZERO;
			srate_q     <= RST_ZERO;
			delay_q     <= RST_ZERO;
			start_q     <= RST_ZERO;
		end else if (I_WR_EN) begin
			case (I_ADDR)
				ADDR_CONFIG:    config_q    <= I_WDATA;
				ADDR_LEDCTL_HI: ledctl_hi_q <= I_WDATA;
				ADDR_LEDCTL_LO: ledctl_lo_q <= I_WDATA;
				ADDR_EFFECT:    effect_q    <= I_WDATA;
				ADDR_FUNC:      func_q      <= I_WDATA;
				ADDR_DIR:       dir_q       <= I_WDATA;
				ADDR_LEVEL:     level_q     <= I_WDATA;
				ADDR_IRQEN:     irqen_q     <= I_WDATA;
				ADDR_SRATE:     srate_q     <= I_WDATA;
				ADDR_DELAY:     delay_q     <= I_WDATA;
				ADDR_START:     start_q     <= I_WDATA;
				default: ;
			endcase
		end
	end

	// duty shadows and the committed copy
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int c = 0; c < NUM_CH; c++) begin
				shadow_q[c] <= RST_ZERO;
				commit_q[c] <= RST_ZERO;
			end
		end else begin
			if (wr_duty) begin
				shadow_q[duty_ch] <= I_WDATA;
			end
			if (wr_commit) begin
				commit_q <= shadow_q;
			end
		end
	end

	// frame memory holds no reset value
	always_ff @(posedge I_CORE_CLK) begin
		if (wr_frame) begin
			frame_mem[frame_idx] <= I_WDATA;
		end
	end

	// ==========================================================
	// frame player
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cur_frame_q <= 3'h0;
			mode_prev_q <= 2'h0;
			timer_q     <= 32'h0;
			frm_on_q    <= 16'h0000;
			for (int c = 0; c < NUM_CH; c++) begin
				frm_duty_q[c] <= RST_ZERO;
			end
		end else begin
			mode_prev_q <= config_q[MODE_MSB:MODE_LSB];
			if (load_frame) begin
				cur_frame_q <= next_frame;
				timer_q     <= hold_cycles - 32'h1;
				frm_on_q    <= {frame_mem[fbase + FRAME_ON_HI], frame_mem[fbase + FRAME_ON_LO]};
				for (int c = 0; c < NUM_CH; c++) begin
					frm_duty_q[c] <= frame_mem[fbase + FRAME_DUTY_OFS + 8'(NUM_CH - 1 - c)];
				end
			end else if (timer_q != 32'h0) begin
				timer_q <= timer_q - 32'h1;
			end
		end
	end

	// audio sample timer, stopped while the divisor is zero
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			srate_cnt_q <= 18'h00000;
			sample_q    <= 1'b0;
		end else begin
			sample_q <= sample_tick;
			if (!srate_on) begin
				// parked at zero so the first tick follows the divisor write at once
				srate_cnt_q <= 18'h00000;
			end else if (sample_tick) begin
				srate_cnt_q <= sample_period - 18'h00001;
			end else begin
				srate_cnt_q <= srate_cnt_q - 18'h00001;
			end
		end
	end

	// ==========================================================
	// gpio, interrupt and read port
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q     <= RST_ZERO;
			irq_n_q     <= 1'b1;
			rdata_q     <= RST_ZERO;
			rvalid_q    <= 1'b0;
			gpio_out_q  <= RST_LEVEL;
			gpio_oe_n_q <= RST_LEVEL;
		end else begin
			state_q     <= I_GPIO_IN;
			irq_n_q     <= !chg_any && (irq_n_q || rd_state);
			rvalid_q    <= I_RD_EN;
			rdata_q     <= rd_state ? state_q : RST_ZERO;
			gpio_out_q  <= level_q;
			gpio_oe_n_q <= ~(func_q & dir_q);
		end
	end

	// audio and current settings
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			gain_q   <= 5'h00;
			isel_q   <= 3'h0;
			amod_q   <= 1'b0;
			agc_en_q <= 1'b0;
		end else begin
			gain_q   <= 5'(effect_q[GAIN_CODE_MSB:GAIN_CODE_LSB]) * GAIN_STEP_DB;
			isel_q   <= effect_q[ISEL_MSB:ISEL_LSB];
			amod_q   <= config_q[AUDIO_MOD_BIT];
			agc_en_q <= effect_q[AGC_EN_BIT];
		end
	end

	assign O_RDATA          = rdata_q;
	assign O_RDATA_VALID    = rvalid_q;
	assign O_CHAN_PWM       = bank_bus.pwm;
	assign O_FULL_SCALE_SEL = isel_q;
	assign O_GPIO_OUT       = gpio_out_q;
	assign O_GPIO_OE_N      = gpio_oe_n_q;
	assign O_IRQ_N          = irq_n_q;
	assign O_ADC_SAMPLE     = sample_q;
	assign O_AUDIO_GAIN_DB  = gain_q;
	assign O_AUDIO_MOD_EN   = amod_q;
	assign O_AGC_EN         = agc_en_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence s_auto_enter;
		(mode == MODE_AUTO) && entering;
	endsequence
	sequence s_frame_shown;
		cur_frame_q == $past(start_q[CODE_MSB:CODE_LSB]) ##1 timer_q != 32'h0;
	endsequence

	property p_irq_set;
		chg_any |=> !O_IRQ_N;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq not raised");
	property p_irq_clear;
		rd_state && !chg_any |=> O_IRQ_N;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq not released");
	property p_commit;
		wr_commit |=> commit_q[0] == $past(shadow_q[0]);
	endproperty
	a_commit: assert property (p_commit) else $error("commit missed");
	property p_duty_map;
		I_WR_EN && I_ADDR == ADDR_DUTY_LO |=> shadow_q[NUM_CH - 1] == $past(I_WDATA);
	endproperty
	a_duty_map: assert property (p_duty_map) else $error("duty order wrong");
	property p_auto_step;
		auto_step |=> cur_frame_q == 3'($past(cur_frame_q) + 3'h1);
	endproperty
	a_auto_step: assert property (p_auto_step) else $error("frame not advanced");
	property p_auto_start;
		s_auto_enter |=> s_frame_shown;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("wrong start frame");
	property p_audio_pick;
		audio_pick |=> cur_frame_q == $past(I_AUDIO_LEVEL[CODE_MSB:CODE_LSB]);
	endproperty
	a_audio_pick: assert property (p_audio_pick) else $error("audio frame wrong");
	property p_gpio_dark;
		func_q == $past(func_q) |=> (O_CHAN_PWM[15:8] & $past(func_q)) == RST_ZERO;
	endproperty
	a_gpio_dark: assert property (p_gpio_dark) else $error("gpio channel lit");
	property p_gain;
		effect_q == $past(effect_q) |=>
			O_AUDIO_GAIN_DB == 5'($past(effect_q[GAIN_CODE_MSB:GAIN_CODE_LSB])) * GAIN_STEP_DB;
	endproperty
	a_gain: assert property (p_gain) else $error("gain wrong");
endmodule
`default_nettype wire

// ### test/host_model.sv
// host model: register strobes and recommended duty codes
`timescale 1ns/100ps
`default_nettype none
module host_model
	import led_pwm_pkg::*;
(
	// clock
	input  wire logic       clk,
	// register port
	output logic            wr_en,
	output logic            rd_en,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	input  wire logic [7:0] rdata,
	input  wire logic       rdata_valid
);
	// gamma corrected breathing codes, first sixteen of 32 steps
	duty_t gamma [16] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0a, 8'h0d, 8'h12,
		8'h16, 8'h1c, 8'h21, 8'h27, 8'h2e, 8'h35, 8'h3d, 8'h45};
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr  = 8'h00;
		wdata = 8'h00;
	end
	// released lines show the inverse so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr  = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		addr  = ~a;
		wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk);
		addr  = a;
		rd_en = 1'b1;
		@(negedge clk);
		d     = rdata;
		v     = rdata_valid;
		rd_en = 1'b0;
		addr  = ~a;
	endtask
	task automatic commit();
		wr(ADDR_COMMIT, 8'h5a);
	endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking testbench of the led pwm frame controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import led_pwm_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        rvalid;
	logic [15:0] pwm;
	logic [2:0]  cur_sel;
	logic [7:0]  gpio_in;
	logic [7:0]  gpio_out;
	logic [7:0]  gpio_oe_n;
	logic        irq_n;
	logic [7:0]  audio;
	logic        sample;
	logic [4:0]  gain;
	logic        mod_en;
	logic        agc_en;
	int          fails;
	int          n_tests;
	logic [15:0] v;
	logic [7:0]  d;
	logic        ok;
	int          n;
	// gain table rows: {data to 03h, gain dB, current select}
	logic [15:0] rows [8] = '{16'h7007, 16'h691e, 16'h5235, 16'h4b4c,
		16'h3463, 16'h2d7a, 16'h1691, 16'h0fa8};
	// ==========================================================
	// design and host
	led_pwm_frame_controller #(.FRAME_BASE_CYCLES(20)) led_pwm_frame_controller_inst (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_WR_EN(wr_en), .I_RD_EN(rd_en),
		.I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_RDATA_VALID(rvalid),
		.O_CHAN_PWM(pwm), .O_FULL_SCALE_SEL(cur_sel), .I_GPIO_IN(gpio_in),
		.O_GPIO_OUT(gpio_out), .O_GPIO_OE_N(gpio_oe_n), .O_IRQ_N(irq_n),
		.I_AUDIO_LEVEL(audio), .O_ADC_SAMPLE(sample), .O_AUDIO_GAIN_DB(gain),
		.O_AUDIO_MOD_EN(mod_en), .O_AGC_EN(agc_en));
	host_model host_model_inst (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata(rdata), .rdata_valid(rvalid));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ==========================================================
	// helpers
	task automatic test_done();
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] dat);
		host_model_inst.wr(a, dat);
		@(negedge clk);
	endtask
	// high cycles of one channel over a full 256 step period
	task automatic high_count(input int ch, output logic [15:0] c);
		c = 16'h0000;
		repeat (2) @(negedge clk);
		repeat (256) begin
			@(negedge clk);
			if (pwm[ch] === 1'b1) c++;
		end
	endtask
	// channels lit over two cycles, hides the single low step of full duty
	task automatic seen(output logic [15:0] s);
		s = pwm;
		@(negedge clk);
		s = s | pwm;
	endtask
	task automatic wait_tick(output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (sample !== 1'b1 && c < 2000);
		if (c >= 2000) begin
			fails++;
			test_done();
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		fails = 0;
		n_tests = 0;
		rst_n = 1'b0;
		gpio_in = 8'h00;
		audio = 8'h00;
		repeat (3) @(negedge clk);
		check({gpio_out, gpio_oe_n}, 16'hffff);
		check({pwm}, 16'h0000);
		check({5'h00, agc_en, mod_en, irq_n, gain, cur_sel}, 16'h0100);
		rst_n = 1'b1;
		w(ADDR_DIR, 8'hff);
		check({8'h00, gpio_oe_n}, 16'h00ff);
		for (int i = 0; i < 8; i++) begin
			w(ADDR_EFFECT, rows[i][15:8]);
			check({7'h00, agc_en, gain, cur_sel}, {7'h00, rows[i][11], rows[i][7:0]});
		end
		// shadow duty only shows after commit
		w(ADDR_DUTY_HI, 8'h04);
		high_count(0, v);
		check(v, 16'h0000);
		host_model_inst.commit();
		high_count(0, v);
		check(v, 16'h0004);
		for (int i = 0; i < 16; i++) begin
			w(8'h18, host_model_inst.gamma[i]);
			host_model_inst.commit();
			high_count(7, v);
			check(v, {8'h00, host_model_inst.gamma[i]});
		end
		// interrupt on enabled input pin only
		w(ADDR_FUNC, 8'hff);
		w(ADDR_DIR, 8'h00);
		w(ADDR_IRQEN, 8'h01);
		gpio_in = 8'h02;
		repeat (3) @(negedge clk);
		check({15'h0000, irq_n}, 16'h0001);
		gpio_in = 8'h03;
		repeat (3) @(negedge clk);
		check({15'h0000, irq_n}, 16'h0000);
		host_model_inst.rd(ADDR_STATE, d, ok);
		check({7'h00, ok, d}, 16'h0103);
		check({15'h0000, irq_n}, 16'h0001);
		host_model_inst.rd(ADDR_EFFECT, d, ok);
		check({7'h00, ok, d}, 16'h0100);
		// gpio outputs only where selected and set as output
		w(ADDR_FUNC, 8'h0f);
		w(ADDR_DIR, 8'h50);
		w(ADDR_LEVEL, 8'ha5);
		check({gpio_out, gpio_oe_n}, 16'ha5ff);
		w(ADDR_FUNC, 8'hff);
		w(ADDR_LEVEL, 8'h00);
		check({gpio_out, gpio_oe_n}, 16'h00af);
		// frame k lights only channel k+1 at full duty
		for (int k = 0; k < 8; k++)
			for (int b = 0; b < 18; b++)
				w(8'(32 + 18 * k + b), (b == 0) ? 8'h00 : (b == 1) ? 8'(1 << k) : 8'hff);
		high_count(0, v);
		check(v, 16'h0004);
		w(ADDR_DELAY, 8'h20);
		w(ADDR_START, 8'h60);
		w(ADDR_CONFIG, 8'ha0);
		repeat (8) @(negedge clk);
		for (int j = 0; j < 10; j++) begin
			seen(v);
			check(v, 16'(1 << ((3 + j) % 8)));
			repeat (39) @(negedge clk);
		end
		// audio frame follows the sampled level
		audio = 8'he0;
		w(ADDR_SRATE, 8'h01);
		w(ADDR_CONFIG, 8'hd0);
		check({15'h0000, mod_en}, 16'h0001);
		wait_tick(n);
		wait_tick(n);
		check(16'(n), 16'h0280);
		repeat (3) @(negedge clk);
		seen(v);
		check(v, 16'h0080);
		audio = 8'h1f;
		wait_tick(n);
		repeat (3) @(negedge clk);
		seen(v);
		check(v, 16'h0001);
		// mode 11 falls back to the committed duties
		w(ADDR_CONFIG, 8'he0);
		high_count(0, v);
		check(v, 16'h0004);
		test_done();
	end
endmodule
`default_nettype wire
